// ==== design/peripheral_address_decoder.sv ====
// Purpose: Address decoder of the bus matrix for two masters
// Assumes: Requests held until ready; addresses synchronous to mclk_i
// Notes: Registered answer one cycle after grant
// Functional notes
// - Fast window 0x5000_0000 to 0x5020_0000, 128 slots.
// - Slow window 0x4000_0000 to 0x4008_0000, 32 slots.
// - Every slot spans 16 kB; index from bits above 14-bit offset.
// - Fast slots: 0 ethernet, 1 dma, 3 usb, rest reserved.
// - Slow slots 0..13 except 5 and 7: watchdog, timers, serial, pwm, spi, rtc, pins, ssp, adc.
// - Slow slots 14..18 can, 23 second i2c, others reserved.
// - Different slave ports serve masters in parallel; same port serialises.
// - Main RAM on own port; two aux RAMs on separate port.
// - Vector area redirectable to alternate region under remap control.
// - Protection fault outside enabled regions or when not permitted; 8x8.
`include "addr_decode_defines.svh"
`default_nettype none
module peripheral_address_decoder
    import addr_decode_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic remap_en_i,
    input wire logic prot_en_i,
    input wire prot_region_t [7:0] prot_regions_i,
    input wire logic [1:0] req_i,
    input wire logic [63:0] addr_i,
    input wire logic [1:0] write_i,
    input wire logic [1:0] priv_i,
    output logic [1:0] ready_o,
    output logic [1:0] error_o,
    output logic [1:0] prot_fault_o,
    output logic [63:0] eff_addr_o,
    output logic [255:0] hs_sel_o,
    output logic [127:0] ls_sel_o,
    output logic [1:0] main_ram_sel_o,
    output logic [1:0] aux_ram_sel_o
);
    typedef struct packed {
        logic [1:0] done;
        logic [1:0] err;
        logic [1:0] fault;
        logic [63:0] eff;
        logic [255:0] hs_sel;
        logic [127:0] ls_sel;
        logic [1:0] main_sel;
        logic [1:0] aux_sel;
    } dec_state_t;

    localparam logic [127:0] HS_LIVE = `HS_SLOT_LIVE_MASK;
    localparam logic [63:0] LS_LIVE = `LS_SLOT_LIVE_MASK;
    dec_state_t st_r;
    dec_state_t st_nxt;
    port_access_if acc [2] ();
    logic [1:0] grant;
    logic [31:0] eff_w [2];
    target_t tgt_w [2];
    logic live_w [2];
    logic fault_w [2];

    function automatic target_t classify(input logic [31:0] a);
        target_t t;
        t = TGT_OTHER;
        if (a >= `HS_WIN_BASE && a < `HS_WIN_END) begin
            t = TGT_HS_PERIPH;
        end else if (a >= `LS_WIN_BASE && a < `LS_WIN_END) begin
            t = TGT_LS_PERIPH;
        end else if (a >= `MAIN_RAM_BASE && a < `MAIN_RAM_BASE + `MAIN_RAM_SIZE) begin
            t = TGT_MAIN_RAM;
        end else if (a >= `AUX_RAM0_BASE && a < `AUX_RAM1_BASE + `AUX_RAM_SIZE) begin
            t = TGT_AUX_RAM;
        end
        return t;
    endfunction

    function automatic logic [2:0] port_of(input target_t t);
        logic [2:0] p;
        case (t)
            TGT_MAIN_RAM: p = 3'h1;
            TGT_AUX_RAM: p = 3'h2;
            TGT_HS_PERIPH: p = 3'h3;
            TGT_LS_PERIPH: p = 3'h4;
            TGT_OTHER: p = 3'h5;
            default: p = 3'h0;
        endcase
        return p;
    endfunction

    function automatic logic prot_ok(input logic [31:0] a, input logic wr, input logic pv);
        logic hit;
        logic [31:0] mask;
        logic [2:0] sub;
        hit = 1'b0;
        for (int i = 0; i < `PROT_REGIONS; i++) begin
            mask = 32'hFFFF_FFFF << prot_regions_i[i].size_log2;
            sub = 3'((a & ~mask) >> (prot_regions_i[i].size_log2 - 5'h03));
            if (prot_regions_i[i].enable && ((a & mask) == (prot_regions_i[i].base & mask))
                && !prot_regions_i[i].sub_disable[sub]) begin
                // Higher region wins on overlap
                hit = (!wr || prot_regions_i[i].write_ok) && (pv || prot_regions_i[i].unpriv_ok);
            end
        end
        return hit;
    endfunction

    generate
        for (genvar m = 0; m < 2; m++) begin : g_master
            always_comb begin
                eff_w[m] = addr_i[32*m +: 32];
                if (remap_en_i && addr_i[32*m +: 32] < `VECTOR_AREA_SIZE) begin
                    eff_w[m] = addr_i[32*m +: 32] + `VECTOR_REMAP_BASE;
                end
                tgt_w[m] = classify(eff_w[m]);
                live_w[m] = 1'b1;
                if (tgt_w[m] == TGT_HS_PERIPH) begin
                    live_w[m] = HS_LIVE[eff_w[m][`HS_SLOT_MSB:`SLOT_OFFSET_BITS]];
                end else if (tgt_w[m] == TGT_LS_PERIPH) begin
                    live_w[m] = LS_LIVE[eff_w[m][`LS_SLOT_MSB-1:`SLOT_OFFSET_BITS]];
                end
                fault_w[m] = prot_en_i && !prot_ok(eff_w[m], write_i[m], priv_i[m]);
            end
            assign acc[m].req = req_i[m] && !st_r.done[m];
            assign acc[m].port = port_of(tgt_w[m]);
            assign grant[m] = acc[m].grant;
        end
    endgenerate

    port_arbiter u_arb (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .m0(acc[0]),
        .m1(acc[1])
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.done = '0;
        for (int m = 0; m < 2; m++) begin
            st_nxt.hs_sel[128*m +: 128] = '0;
            st_nxt.ls_sel[64*m +: 64] = '0;
            st_nxt.main_sel[m] = 1'b0;
            st_nxt.aux_sel[m] = 1'b0;
            if (grant[m]) begin
                st_nxt.done[m] = 1'b1;
                st_nxt.eff[32*m +: 32] = eff_w[m];
                st_nxt.fault[m] = fault_w[m];
                st_nxt.err[m] = fault_w[m] || !live_w[m];
                if (!fault_w[m] && live_w[m]) begin
                    case (tgt_w[m])
                        TGT_HS_PERIPH: begin
                            // One-hot slot select, 16 kB granules
                            st_nxt.hs_sel[128*m + 32'(eff_w[m][`HS_SLOT_MSB:`SLOT_OFFSET_BITS])] = 1'b1;
                        end
                        TGT_LS_PERIPH: begin
                            st_nxt.ls_sel[64*m + 32'(eff_w[m][`LS_SLOT_MSB:`SLOT_OFFSET_BITS])] = 1'b1;
                        end
                        TGT_MAIN_RAM: begin
                            st_nxt.main_sel[m] = 1'b1;
                        end
                        TGT_AUX_RAM: begin
                            st_nxt.aux_sel[m] = 1'b1;
                        end
                        default: begin
                            st_nxt.err[m] = st_nxt.err[m];
                        end
                    endcase
                end
            end else begin
                st_nxt.err[m] = 1'b0;
                st_nxt.fault[m] = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ready_o = st_r.done;
    assign error_o = st_r.err;
    assign prot_fault_o = st_r.fault;
    assign eff_addr_o = st_r.eff;
    assign hs_sel_o = st_r.hs_sel;
    assign ls_sel_o = st_r.ls_sel;
    assign main_ram_sel_o = st_r.main_sel;
    assign aux_ram_sel_o = st_r.aux_sel;
endmodule
`default_nettype wire

// ==== inc/addr_decode_defines.svh ====
// Purpose: Address map constants for the peripheral address decoder
// Assumes: 32-bit byte addresses
// Notes: Slot size is 16 kB in both peripheral windows
`ifndef ADDR_DECODE_DEFINES_SVH
`define ADDR_DECODE_DEFINES_SVH

`define HS_WIN_BASE 32'h5000_0000
`define HS_WIN_END 32'h5020_0000
`define HS_SLOT_COUNT 128
`define LS_WIN_BASE 32'h4000_0000
`define LS_WIN_END 32'h4008_0000
`define LS_SLOT_COUNT 64
`define LS_SLOT_USED 32
`define SLOT_OFFSET_BITS 14
`define HS_SLOT_MSB 20
`define LS_SLOT_MSB 19
`define HS_SLOT_ETHERNET 7'h00
`define HS_SLOT_DMA 7'h01
`define HS_SLOT_USB 7'h03
`define HS_SLOT_LIVE_MASK 128'h0000_0000_0000_0000_0000_0000_0000_000B
`define LS_SLOT_LIVE_MASK 64'h0000_0000_0087_FF5F
`define MAIN_RAM_BASE 32'h1000_0000
`define MAIN_RAM_SIZE 32'h0000_8000
`define AUX_RAM0_BASE 32'h2007_C000
`define AUX_RAM1_BASE 32'h2008_0000
`define AUX_RAM_SIZE 32'h0000_4000
`define VECTOR_AREA_SIZE 32'h0000_0200
`define VECTOR_REMAP_BASE 32'h1000_0000
`define PROT_REGIONS 8
`define PROT_SUBREGIONS 8

`endif

// ==== inc/addr_decode_pkg.sv ====
// Purpose: Types for the peripheral address decoder
// Assumes: Included after the defines header
// Notes: None
`default_nettype none
package addr_decode_pkg;
    typedef enum {
        TGT_NONE,
        TGT_MAIN_RAM,
        TGT_AUX_RAM,
        TGT_HS_PERIPH,
        TGT_LS_PERIPH,
        TGT_OTHER
    } target_t;

    typedef struct packed {
        logic [31:0] base;
        logic [4:0] size_log2;
        logic [7:0] sub_disable;
        logic enable;
        logic write_ok;
        logic unpriv_ok;
    } prot_region_t;
endpackage
`default_nettype wire

// ==== inc/port_access_if.sv ====
// Purpose: One master's access request toward the decoder's port router
// Assumes: Single clock
// Notes: Grant is combinational
`default_nettype none
interface port_access_if;
    logic req;
    logic [2:0] port;
    logic grant;
    modport master (output req, output port, input grant);
    modport arbiter (input req, input port, output grant);
endinterface
`default_nettype wire

// ==== design/port_arbiter.sv ====
// Purpose: Per slave port round-robin grant among masters
// Assumes: Request held until granted
// Notes: Masters on different ports are granted together
`default_nettype none
module port_arbiter
    import addr_decode_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    port_access_if.arbiter m0,
    port_access_if.arbiter m1
);
    typedef struct packed {
        logic [7:0] last_m1;
    } arb_state_t;

    arb_state_t st_r;
    arb_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        m0.grant = 1'b0;
        m1.grant = 1'b0;
        if (m0.req && m1.req && m0.port == m1.port) begin
            // Same port: serialise, alternate winners
            if (st_r.last_m1[m0.port]) begin
                m0.grant = 1'b1;
            end else begin
                m1.grant = 1'b1;
            end
            st_nxt.last_m1[m0.port] = ~st_r.last_m1[m0.port];
        end else begin
            // Different ports run in parallel
            m0.grant = m0.req;
            m1.grant = m1.req;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== test/addr_decode_asserts.sv ====
// Purpose: Port checks on master 0
// Assumes: Bound to the decoder
// Notes: None
`default_nettype none
module addr_decode_asserts (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [1:0] req_i,
    input wire logic [1:0] ready_o,
    input wire logic [1:0] error_o,
    input wire logic [1:0] prot_fault_o,
    input wire logic [63:0] eff_addr_o,
    input wire logic [255:0] hs_sel_o,
    input wire logic [127:0] ls_sel_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_req; $rose(req_i[0]); endsequence
    sequence s_ans; ##[1:3] ready_o[0]; endsequence
    answer_bound_a: assert property (s_req |-> s_ans)
        else $error("no answer");
    ready_pulse_a: assert property (ready_o[0] |=> !ready_o[0])
        else $error("ready held");
    err_no_sel_a:
        assert property (error_o[0] |-> !(|hs_sel_o[127:0]) && !(|ls_sel_o[63:0]))
        else $error("select on error");
    fault_err_a: assert property (prot_fault_o[0] |-> error_o[0] && ready_o[0])
        else $error("fault alone");
    hs_map_a:
        assert property (|hs_sel_o[127:0] |-> hs_sel_o[eff_addr_o[20:14]] && eff_addr_o[31:21] == 11'h280)
        else $error("fast select");
    ls_map_a:
        assert property (|ls_sel_o[63:0] |-> $onehot(ls_sel_o[63:0]) && eff_addr_o[31:20] == 12'h400)
        else $error("slow select");
    hs_live_a: assert property ((hs_sel_o[127:0] & ~128'hB) == 128'h0)
        else $error("fast reserved");
    ls_live_a: assert property ((ls_sel_o[63:0] & ~64'h87FF5F) == 64'h0)
        else $error("slow reserved");
endmodule
bind peripheral_address_decoder addr_decode_asserts u_chk (.mclk_i, .rst_n_i, .req_i, .ready_o,
    .error_o, .prot_fault_o, .eff_addr_o, .hs_sel_o, .ls_sel_o);
`default_nettype wire

// ==== test/bus_master_model.sv ====
// Purpose: Master holding an access until answered
// Assumes: start_i lasts one cycle
// Notes: Idle address is the inverse of the last
`default_nettype none
module bus_master_model (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [31:0] a_i,
    input wire logic ready_i,
    output logic req_o,
    output logic [31:0] addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        req_o = 1'b0;
        addr_o = 32'hFFFF_FFFF;
    end
    always @(posedge clk_i) begin
        if (start_i) begin
            req_o <= 1'b1;
            addr_o <= a_i;
        end else if (ready_i && req_o) begin
            req_o <= 1'b0;
            addr_o <= ~addr_o;
        end
    end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Purpose: Scenario bench for the decoder
// Assumes: Two master models
// Notes: None
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("[ERR] %s %0h %0h", n, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import addr_decode_pkg::*;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, remap_en_i = 1'b0, prot_en_i = 1'b0;
    prot_region_t [7:0] prot_regions_i = '0;
    logic [1:0] st = 2'h0, write_i = 2'h0, priv_i = 2'h3, f1;
    logic [1:0] ready_o, error_o, prot_fault_o, main_ram_sel_o, aux_ram_sel_o;
    wire logic [1:0] req_i;
    wire logic [63:0] addr_i;
    logic [63:0] eff_addr_o, ls0;
    logic [255:0] hs_sel_o;
    logic [127:0] ls_sel_o, hs0;
    logic [31:0] a0 = 32'h0, a1 = 32'h0;
    logic [3:0] f0;
    int err_count = 0, n_tests = 0, c0, c1;
    always #4 mclk_i = ~mclk_i;
    bus_master_model u_m0 (.clk_i(mclk_i), .start_i(st[0]), .a_i(a0), .ready_i(ready_o[0]),
        .req_o(req_i[0]), .addr_o(addr_i[31:0]));
    bus_master_model u_m1 (.clk_i(mclk_i), .start_i(st[1]), .a_i(a1), .ready_i(ready_o[1]),
        .req_o(req_i[1]), .addr_o(addr_i[63:32]));
    peripheral_address_decoder u_dut (.mclk_i, .rst_n_i, .remap_en_i, .prot_en_i, .prot_regions_i,
        .req_i, .addr_i, .write_i, .priv_i, .ready_o, .error_o, .prot_fault_o, .eff_addr_o, .hs_sel_o,
        .ls_sel_o, .main_ram_sel_o, .aux_ram_sel_o);
    task automatic run(input logic [1:0] m, input logic [31:0] x, input logic [31:0] y);
        a0 = x;
        a1 = y;
        st = m;
        c0 = 99;
        c1 = 99;
        @(posedge mclk_i) #1 st = 2'h0;
        for (int i = 0; i < 6; i++) begin
            @(posedge mclk_i) #1;
            if (ready_o[0] === 1'b1) begin
                c0 = i;
                f0 = {error_o[0], prot_fault_o[0], main_ram_sel_o[0], aux_ram_sel_o[0]};
                hs0 = hs_sel_o[127:0];
                ls0 = ls_sel_o[63:0];
            end
            if (ready_o[1] === 1'b1) begin
                c1 = i;
                f1 = {main_ram_sel_o[1], aux_ram_sel_o[1]};
            end
        end
    endtask
    task automatic t_win(input bit h);
        logic [127:0] mk;
        int s;
        mk = h ? 128'hB : 128'h87FF5F;
        for (int i = 0; i < (h ? 9 : 32); i++) begin
            s = (h && i == 8) ? 127 : i;
            run(2'h1, (h ? 32'h5000_0000 : 32'h4000_0000) + (s << 14), 32'h0);
            `CHK("sel", mk[s] ? 128'h1 << s : 128'h0, h ? hs0 : {64'h0, ls0})
            `CHK("err", !mk[s], f0[3])
        end
    endtask
    task automatic t_par();
        run(2'h3, 32'h5000_4000, 32'h4000_0000);
        `CHK("par", 0, c0 | c1)
        run(2'h3, 32'h5000_0000, 32'h5000_C000);
        `CHK("ser", 1, (c0 - c1) * (c0 - c1))
    endtask
    task automatic t_ram();
        run(2'h3, 32'h1000_0000, 32'h2007_C000);
        `CHK("ram", 6'h09, {f0, f1})
        `CHK("conc", c0, c1)
        run(2'h1, 32'h4008_0000, 32'h0);
        `CHK("other", 4'h0, f0)
    endtask
    task automatic t_remap();
        remap_en_i = 1'b1;
        run(2'h1, 32'h100, 32'h0);
        `CHK("remap", 32'h1000_0100, eff_addr_o[31:0])
        remap_en_i = 1'b0;
        run(2'h1, 32'h100, 32'h0);
        `CHK("plain", 32'h100, eff_addr_o[31:0])
    endtask
    task automatic t_prot();
        prot_en_i = 1'b1;
        write_i = 2'h1;
        run(2'h1, 32'h4000_0000, 32'h0);
        `CHK("nohit", 4'hC, f0)
        prot_regions_i[7] = '{32'h4000_0000, 5'h14, 8'h0, 1'b1, 1'b0, 1'b1};
        run(2'h1, 32'h4000_0000, 32'h0);
        `CHK("ro", 4'hC, f0)
        write_i = 2'h0;
        run(2'h1, 32'h4000_0000, 32'h0);
        `CHK("rd", 68'h0_0000_0000_0000_0001, {f0, ls0})
        prot_en_i = 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge mclk_i);
        #1 rst_n_i = 1'b1;
        t_win(1'b1);
        t_win(1'b0);
        t_par();
        t_ram();
        t_remap();
        t_prot();
        tally_and_finish();
    end
    initial begin
        #50us;
        err_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
